// File: t8_defines.svh
`ifndef T8_DEFINES_SVH
`define T8_DEFINES_SVH

// register map, byte offsets on the local register port
`define T8_ADDR_W        3
`define T8_OFF_COUNTER   3'h0
`define T8_OFF_COMPARE_A 3'h1
`define T8_OFF_CONTROL_A 3'h2
`define T8_OFF_CONTROL_B 3'h3
`define T8_OFF_ASYNC     3'h4
`define T8_OFF_FLAGS     3'h5

// control a fields
`define T8_CTLA_COM_HI   7
`define T8_CTLA_COM_LO   6
`define T8_CTLA_WGM_HI   1
`define T8_CTLA_WGM_LO   0
// control b fields
`define T8_CTLB_FORCE    7
// async status fields
`define T8_AS_EXT_EN     6
`define T8_AS_SEL        5
`define T8_AS_CNT_BUSY   4
`define T8_AS_CMP_BUSY   3
`define T8_AS_CTLA_BUSY  1
`define T8_AS_CTLB_BUSY  0
// flag fields, write one to clear
`define T8_FLAG_OVF      0
`define T8_FLAG_CMP      1

// waveform modes
`define T8_WGM_NORMAL    2'h0
`define T8_WGM_PWM_PC    2'h1
`define T8_WGM_CTC       2'h2
`define T8_WGM_PWM_FAST  2'h3
// compare output actions
`define T8_COM_NONE      2'h0
`define T8_COM_TOGGLE    2'h1
`define T8_COM_CLEAR     2'h2
`define T8_COM_SET       2'h3

// counter limits and reset values
`define T8_CNT_MAX       8'hff
`define T8_CNT_BOTTOM    8'h00
`define T8_RESET_BYTE    8'h00

`endif

// File: t8_partner.sv
`timescale 1ns/1ps
`default_nettype none

// interrupt controller and clock sources seen by the timer
module t8_partner (
    // clock
    input  wire logic clock,
    // bench controls
    input  wire logic ack_en,
    input  wire logic ext_run,
    // flags from the timer
    input  wire logic overflow_flag,
    input  wire logic compare_flag,
    // acknowledges and clock sources
    output var  logic ovf_int_ack,
    output var  logic cmp_int_ack,
    output var  logic lf_osc_clock,
    output var  logic crystal_input_pin
);
    logic [3:0] div_cnt;    // divider for both slow clocks

    // everything starts low so no input is unknown at time zero
    initial begin
        div_cnt = 4'h0;
        {ovf_int_ack, cmp_int_ack, lf_osc_clock, crystal_input_pin} = 4'h0;
    end

    // one-cycle acknowledges; the low-frequency clock runs free,
    // the external clock only in bursts so busy bits can be caught
    always @(posedge clock) begin
        div_cnt           <= div_cnt + 4'h1;
        ovf_int_ack       <= ack_en && overflow_flag && !ovf_int_ack;
        cmp_int_ack       <= ack_en && compare_flag && !cmp_int_ack;
        lf_osc_clock      <= div_cnt[3];
        crystal_input_pin <= ext_run && div_cnt[2];
    end
endmodule

`default_nettype wire

// File: t8_pkg.sv
`include "t8_defines.svh"

package t8_pkg;

    typedef logic [`T8_ADDR_W-1:0] t8_addr_t;   // register port address
    typedef logic [7:0]            t8_byte_t;   // register data

    // timer clock source, one-hot
    typedef enum logic [1:0] {
        T8_CLK_SYNC  = 2'b01,
        T8_CLK_ASYNC = 2'b10
    } t8_clk_e;

    // whole state of the timer
    typedef struct packed {
        t8_clk_e    mode;
        t8_byte_t   cnt;
        t8_byte_t   cmp;
        logic [1:0] com;
        logic [1:0] wgm;
        logic       ext_en;
        logic       async_sel;
        t8_byte_t   cnt_tmp;
        t8_byte_t   cmp_tmp;
        logic [1:0] com_tmp;
        logic [1:0] wgm_tmp;
        logic       frc_tmp;
        logic       cnt_busy;
        logic       cmp_busy;
        logic       ctla_busy;
        logic       ctlb_busy;
        logic       blk;
        logic       ovf;
        logic       cmpf;
        logic       oc;
        logic       oc_oe;
        logic       osc_en;
        logic       buf_en;
        logic       src_prev;
        t8_byte_t   rdata;
    } t8_state_s;

endpackage

// File: t8_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop level synchroniser, resets low
module t8_sync (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // level in and synchronised level out
    input  wire logic din,
    output var  logic dout
);

    logic meta_reg;  // first stage, read only by the second

    // plain shift through two stages
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            dout     <= 1'b0;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// File: t8_timer.sv
// Functional notes
// - mode zero leaves compare output untouched
// - mode change acts at next match; force immediate
// - only waveform mode steers counting
// - output mode picks set/clear/toggle or polarity
// - normal mode counts up, wraps to zero
// - overflow flag set when counter wraps
// - overflow flag cleared on interrupt acknowledge
// - counter writable anytime in normal mode
// - clear-on-match mode restarts at zero after a match
// - counter readable, writable, resets to zero
// - counter write blocks next compare match
// - compare value checked against counter continuously
// - output driven only when direction is output
// - async status bit seven reads zero
// - external buffer on, crystal only when off
// - async select picks timer clock source
// - async select forced low without suitable clock
// - counter write sets busy until loaded
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "t8_defines.svh"

module t8_timer (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // register port
    input  wire t8_pkg::t8_addr_t addr,
    input  wire t8_pkg::t8_byte_t wr_data,
    input  wire logic             wr_stb,
    input  wire logic             rd_stb,
    output var  t8_pkg::t8_byte_t rd_data,
    // clock system
    input  wire logic             sys_clock_src_ok,
    input  wire logic             lf_osc_clock,
    input  wire logic             crystal_input_pin,
    output var  logic             xtal_osc_en,
    output var  logic             ext_clk_buf_en,
    // interrupt side
    input  wire logic             ovf_int_ack,
    input  wire logic             cmp_int_ack,
    output var  logic             overflow_flag,
    output var  logic             compare_flag,
    // compare output pin
    input  wire logic             pin_a2_direction,
    output var  logic             compare_output_a_pin,
    output var  logic             compare_output_a_oe
);
    import t8_pkg::*;

    t8_state_s state_reg;     // all registered state
    t8_state_s state_next;    // its next value
    logic      rst_sync_n;    // released reset
    logic      lf_osc_sync;   // crystal oscillator, synchronised
    logic      ext_clk_sync;  // external clock pin, synchronised

    // reset is released through two flops, assertion stays asynchronous
    t8_sync u_rst_sync (
        .clock (clock),
        .rst_n (rst_n),
        .din   (1'b1),
        .dout  (rst_sync_n)
    );

    // the slow clock sources are pins: two flops before any use
    t8_sync u_osc_sync (
        .clock (clock),
        .rst_n (rst_sync_n),
        .din   (lf_osc_clock),
        .dout  (lf_osc_sync)
    );

    t8_sync u_ext_sync (
        .clock (clock),
        .rst_n (rst_sync_n),
        .din   (crystal_input_pin),
        .dout  (ext_clk_sync)
    );

    // register port address match, used for every write decode
    function automatic logic hit(input t8_addr_t a, input t8_addr_t off);
        hit = (a == off);
    endfunction

    // pwm waveform modes
    function automatic logic is_pwm(input logic [1:0] w);
        is_pwm = (w == `T8_WGM_PWM_PC) || (w == `T8_WGM_PWM_FAST);
    endfunction

    // non-pwm compare action applied to the current output level
    function automatic logic oc_action(input logic [1:0] c, input logic cur);
        case (c)
            `T8_COM_TOGGLE: oc_action = ~cur;
            `T8_COM_CLEAR:  oc_action = 1'b0;
            `T8_COM_SET:    oc_action = 1'b1;
            default:        oc_action = cur;  // no action
        endcase
    endfunction

    // next-state logic
    always_comb begin
        logic     tick;       // one timer clock step
        logic     src_now;    // selected slow clock level
        logic     match;      // compare match this step
        logic     wr_cnt;     // software writes
        logic     wr_cmp;
        logic     wr_ctla;
        logic     wr_ctlb;
        logic     wr_as;
        logic     frc_now;    // force strobe to apply now
        logic     cnt_load;   // counter loaded this step
        t8_byte_t cnt_load_v;

        state_next = state_reg;
        tick       = 1'b0;
        src_now    = state_reg.ext_en ? ext_clk_sync : lf_osc_sync;
        wr_cnt     = wr_stb && hit(addr, `T8_OFF_COUNTER);
        wr_cmp     = wr_stb && hit(addr, `T8_OFF_COMPARE_A);
        wr_ctla    = wr_stb && hit(addr, `T8_OFF_CONTROL_A);
        wr_ctlb    = wr_stb && hit(addr, `T8_OFF_CONTROL_B);
        wr_as      = wr_stb && hit(addr, `T8_OFF_ASYNC);
        frc_now    = 1'b0;
        cnt_load   = 1'b0;
        cnt_load_v = state_reg.cnt;
        match      = 1'b0;

        // timer clock: every system clock, or each rising slow edge
        state_next.src_prev = src_now;
        case (state_reg.mode)
            T8_CLK_SYNC:  tick = 1'b1;
            T8_CLK_ASYNC: tick = src_now && !state_reg.src_prev;
            default:      tick = 1'b0;
        endcase

        // synchronous mode: writes land at once
        if (state_reg.mode == T8_CLK_SYNC) begin
            if (wr_cnt) begin
                cnt_load   = 1'b1;
                cnt_load_v = wr_data;
            end
            if (wr_cmp) begin
                state_next.cmp = wr_data;
            end
            if (wr_ctla) begin
                // new output mode only acts at a later match
                state_next.com = wr_data[`T8_CTLA_COM_HI:`T8_CTLA_COM_LO];
                state_next.wgm = wr_data[`T8_CTLA_WGM_HI:`T8_CTLA_WGM_LO];
            end
            frc_now = wr_ctlb && wr_data[`T8_CTLB_FORCE];
        end else begin
            // asynchronous mode: park the write, mark busy
            if (tick && state_reg.cnt_busy && !wr_cnt) begin
                cnt_load            = 1'b1;
                cnt_load_v          = state_reg.cnt_tmp;
                state_next.cnt_busy = 1'b0;
            end
            if (tick && state_reg.cmp_busy && !wr_cmp) begin
                state_next.cmp      = state_reg.cmp_tmp;
                state_next.cmp_busy = 1'b0;
            end
            if (tick && state_reg.ctla_busy && !wr_ctla) begin
                state_next.com       = state_reg.com_tmp;
                state_next.wgm       = state_reg.wgm_tmp;
                state_next.ctla_busy = 1'b0;
            end
            if (tick && state_reg.ctlb_busy && !wr_ctlb) begin
                frc_now              = state_reg.frc_tmp;
                state_next.ctlb_busy = 1'b0;
            end
            // a write wins over a transfer in the same cycle
            if (wr_cnt) begin
                state_next.cnt_tmp  = wr_data;
                state_next.cnt_busy = 1'b1;
            end
            if (wr_cmp) begin
                state_next.cmp_tmp  = wr_data;
                state_next.cmp_busy = 1'b1;
            end
            if (wr_ctla) begin
                state_next.com_tmp   = wr_data[`T8_CTLA_COM_HI:`T8_CTLA_COM_LO];
                state_next.wgm_tmp   = wr_data[`T8_CTLA_WGM_HI:`T8_CTLA_WGM_LO];
                state_next.ctla_busy = 1'b1;
            end
            if (wr_ctlb) begin
                state_next.frc_tmp   = wr_data[`T8_CTLB_FORCE];
                state_next.ctlb_busy = 1'b1;
            end
        end

        // counting; only the waveform mode chooses the sequence
        if (cnt_load) begin
            state_next.cnt = cnt_load_v;
            state_next.blk = 1'b1;
        end else if (tick) begin
            match          = (state_reg.cnt == state_reg.cmp) && !state_reg.blk;
            state_next.blk = 1'b0;
            case (state_reg.wgm)
                `T8_WGM_CTC: begin
                    if (match) begin
                        state_next.cnt = `T8_CNT_BOTTOM;
                    end else begin
                        state_next.cnt = state_reg.cnt + 8'h01;
                    end
                end
                default: begin
                    // normal and pwm: plain up count with wrap
                    state_next.cnt = state_reg.cnt + 8'h01;
                end
            endcase
            // set only by counting; the wrap to zero marks the overflow
            if (state_reg.cnt == `T8_CNT_MAX) begin
                state_next.ovf = 1'b1;
            end
            if (match) begin
                state_next.cmpf = 1'b1;
            end
        end

        // compare output waveform
        if (is_pwm(state_reg.wgm)) begin
            // pwm: clear-on-match non-inverted, set-on-match inverted
            if (tick && !cnt_load && match) begin
                case (state_reg.com)
                    `T8_COM_CLEAR: state_next.oc = 1'b0;
                    `T8_COM_SET:   state_next.oc = 1'b1;
                    default:       state_next.oc = state_reg.oc;
                endcase
            end else if (tick && !cnt_load && state_reg.cnt == `T8_CNT_MAX) begin
                case (state_reg.com)
                    `T8_COM_CLEAR: state_next.oc = 1'b1;
                    `T8_COM_SET:   state_next.oc = 1'b0;
                    default:       state_next.oc = state_reg.oc;
                endcase
            end
        end else if (match || frc_now) begin
            // force acts without a match and without setting the flag
            state_next.oc = oc_action(state_reg.com, state_reg.oc);
        end

        // flag clearing: acknowledge or write one; a set in the same cycle wins
        if ((ovf_int_ack || (wr_stb && hit(addr, `T8_OFF_FLAGS)
                && wr_data[`T8_FLAG_OVF])) && !state_next.ovf) begin
            state_next.ovf = 1'b0;
        end
        if (ovf_int_ack && !(tick && !cnt_load && state_reg.cnt == `T8_CNT_MAX)) begin
            state_next.ovf = 1'b0;
        end
        if (wr_stb && hit(addr, `T8_OFF_FLAGS) && wr_data[`T8_FLAG_OVF]
                && !(tick && !cnt_load && state_reg.cnt == `T8_CNT_MAX)) begin
            state_next.ovf = 1'b0;
        end
        if ((cmp_int_ack || (wr_stb && hit(addr, `T8_OFF_FLAGS)
                && wr_data[`T8_FLAG_CMP])) && !match) begin
            state_next.cmpf = 1'b0;
        end

        // async status: external enable, source select with guard
        if (wr_as) begin
            state_next.ext_en    = wr_data[`T8_AS_EXT_EN];
            state_next.async_sel = wr_data[`T8_AS_SEL];
        end
        // only a suitable system clock may keep the slow source selected
        if (!sys_clock_src_ok) begin
            state_next.async_sel = 1'b0;
        end
        // source change: contents are left as they are, software reloads them
        state_next.mode = state_next.async_sel ? T8_CLK_ASYNC : T8_CLK_SYNC;
        if (!state_next.async_sel) begin
            // no slow domain left to transfer into
            state_next.cnt_busy  = 1'b0;
            state_next.cmp_busy  = 1'b0;
            state_next.ctla_busy = 1'b0;
            state_next.ctlb_busy = 1'b0;
        end

        // oscillator and input buffer enables
        state_next.osc_en = !state_next.ext_en;
        state_next.buf_en = state_next.ext_en && state_next.async_sel;

        // pin drives only with direction set and an output mode chosen
        state_next.oc_oe = pin_a2_direction && (state_next.com != `T8_COM_NONE);

        // read data stand in the cycle after the strobe
        state_next.rdata = `T8_RESET_BYTE;
        if (rd_stb) begin
            case (addr)
                `T8_OFF_COUNTER:   state_next.rdata = state_reg.cnt;
                `T8_OFF_COMPARE_A: state_next.rdata = state_reg.cmp;
                `T8_OFF_CONTROL_A: begin
                    state_next.rdata[`T8_CTLA_COM_HI:`T8_CTLA_COM_LO] = state_reg.com;
                    state_next.rdata[`T8_CTLA_WGM_HI:`T8_CTLA_WGM_LO] = state_reg.wgm;
                end
                `T8_OFF_ASYNC: begin
                    // bit seven and bit two stay zero
                    state_next.rdata[`T8_AS_EXT_EN]    = state_reg.ext_en;
                    state_next.rdata[`T8_AS_SEL]       = state_reg.async_sel;
                    state_next.rdata[`T8_AS_CNT_BUSY]  = state_reg.cnt_busy;
                    state_next.rdata[`T8_AS_CMP_BUSY]  = state_reg.cmp_busy;
                    state_next.rdata[`T8_AS_CTLA_BUSY] = state_reg.ctla_busy;
                    state_next.rdata[`T8_AS_CTLB_BUSY] = state_reg.ctlb_busy;
                end
                `T8_OFF_FLAGS: begin
                    state_next.rdata[`T8_FLAG_OVF] = state_reg.ovf;
                    state_next.rdata[`T8_FLAG_CMP] = state_reg.cmpf;
                end
                default: state_next.rdata = `T8_RESET_BYTE;  // force strobe reads zero
            endcase
        end
    end

    // state register; everything resets to zero except sync mode and crystal oscillator on
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg        <= '0;
            state_reg.mode   <= T8_CLK_SYNC;
            state_reg.osc_en <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state flops
    assign rd_data              = state_reg.rdata;
    assign xtal_osc_en          = state_reg.osc_en;
    assign ext_clk_buf_en       = state_reg.buf_en;
    assign overflow_flag        = state_reg.ovf;
    assign compare_flag         = state_reg.cmpf;
    assign compare_output_a_pin = state_reg.oc;
    assign compare_output_a_oe  = state_reg.oc_oe;

endmodule

`default_nettype wire

// File: t8_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none

// port-level checker, bound onto the timer
module t8_timer_sva (
    // clock and reset
    input wire logic             clock,
    input wire logic             rst_n,
    // register port
    input wire t8_pkg::t8_addr_t addr,
    input wire t8_pkg::t8_byte_t wr_data,
    input wire logic             wr_stb,
    input wire logic             rd_stb,
    input wire t8_pkg::t8_byte_t rd_data,
    // clock system
    input wire logic             sys_clock_src_ok,
    input wire logic             xtal_osc_en,
    input wire logic             ext_clk_buf_en,
    // interrupt side
    input wire logic             ovf_int_ack,
    input wire logic             cmp_int_ack,
    input wire logic             overflow_flag,
    input wire logic             compare_flag,
    // compare output pin
    input wire logic             pin_a2_direction,
    input wire logic             compare_output_a_oe
);
    import t8_pkg::*;

    // one clock domain
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // read data stand only after a read strobe
    a_rd_quiet: assert property (!$past(rd_stb) |-> rd_data == 8'h00)
        else $error("read data outside read slot");
    // sync counter load reads back unchanged
    a_cnt_readback: assert property (
        wr_stb && addr == 3'h0 && !ext_clk_buf_en ##1 rd_stb && addr == 3'h0
        |=> rd_data == $past(wr_data, 2))
        else $error("counter load not read back");
    // reserved status bits read zero
    a_bit7_zero: assert property (
        rd_stb && addr == 3'h4 |=> rd_data[7] == 1'b0 && rd_data[2] == 1'b0)
        else $error("reserved status bit set");
    // pin driver needs direction
    a_oe_needs_dir: assert property (!pin_a2_direction [*2] |-> !compare_output_a_oe)
        else $error("output enabled at input");
    // crystal and buffer exclusive
    a_xtal_excl: assert property (!(xtal_osc_en && ext_clk_buf_en))
        else $error("crystal and buffer both on");
    // external enable stops the crystal
    a_ext_stops_xtal: assert property (
        wr_stb && addr == 3'h4 && wr_data[6] |-> ##[1:2] !xtal_osc_en)
        else $error("crystal kept running");
    // unsuitable system clock drops the buffer
    a_buf_needs_src: assert property (!sys_clock_src_ok [*3] |-> !ext_clk_buf_en)
        else $error("buffer on without suitable clock");
    // select and busy forced low
    a_async_forced: assert property (
        rd_stb && addr == 3'h4 && !sys_clock_src_ok && !$past(sys_clock_src_ok)
        |=> rd_data[5:0] == 6'h00)
        else $error("async select not forced low");
    // overflow flag leaves only on ack or clear
    a_ovf_sticky: assert property (
        overflow_flag && !ovf_int_ack && !(wr_stb && addr == 3'h5 && wr_data[0])
        |=> overflow_flag)
        else $error("overflow flag dropped");
    // compare flag leaves only on ack or clear
    a_cmp_sticky: assert property (
        compare_flag && !cmp_int_ack && !(wr_stb && addr == 3'h5 && wr_data[1])
        |=> compare_flag)
        else $error("compare flag dropped");
endmodule

bind t8_timer t8_timer_sva sva_u (
    .clock, .rst_n, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data, .sys_clock_src_ok,
    .xtal_osc_en, .ext_clk_buf_en, .ovf_int_ack, .cmp_int_ack, .overflow_flag,
    .compare_flag, .pin_a2_direction, .compare_output_a_oe
);

`default_nettype wire

// File: t8_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none

// self-checking bench: reads queued, judged by a monitor
module t8_timer_tb;
    import t8_pkg::*;

    // design ports
    logic     clock, rst_n, wr_stb, rd_stb, sys_clock_src_ok;
    logic     lf_osc_clock, crystal_input_pin, xtal_osc_en, ext_clk_buf_en;
    logic     ovf_int_ack, cmp_int_ack, overflow_flag, compare_flag;
    logic     pin_a2_direction, compare_output_a_pin, compare_output_a_oe;
    t8_addr_t addr;
    t8_byte_t wr_data, rd_data;
    // bench state
    logic     ack_en, ext_run, rd_pend;
    t8_byte_t exp_q[$];
    t8_byte_t val;
    int       n_errors = 0;
    int       tests_run = 0;
    int       cycles = 0;
    int       seed;
    // output mode table and the pin level each leaves behind
    logic [1:0] com_tab[5] = '{2'h3, 2'h2, 2'h0, 2'h3, 2'h0};
    logic       pin_tab[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

    t8_timer dut_u (
        .clock, .rst_n, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
        .sys_clock_src_ok, .lf_osc_clock, .crystal_input_pin, .xtal_osc_en, .ext_clk_buf_en,
        .ovf_int_ack, .cmp_int_ack, .overflow_flag, .compare_flag,
        .pin_a2_direction, .compare_output_a_pin, .compare_output_a_oe
    );

    t8_partner partner_u (
        .clock, .ack_en, .ext_run, .overflow_flag, .compare_flag,
        .ovf_int_ack, .cmp_int_ack, .lf_osc_clock, .crystal_input_pin
    );

    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // compare of a read byte
    task automatic chk_byte(input t8_byte_t e, input t8_byte_t g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED rd_data expected %h seen %h", e, g);
        end
    endtask

    // compare of a single output level
    task automatic chk_bit(input string name, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", name, e, g);
        end
    endtask

    // one write cycle, driven after an edge
    task automatic wr(input t8_addr_t a, input t8_byte_t d);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        rd_stb  <= 1'b0;
        @(posedge clock);
    endtask

    // one read cycle; expected byte queued first
    task automatic rd(input t8_addr_t a, input t8_byte_t e);
        exp_q.push_back(e);
        addr   <= a;
        wr_stb <= 1'b0;
        rd_stb <= 1'b1;
        @(posedge clock);
    endtask

    // both strobes low for n cycles
    task automatic idle(input int n);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        repeat (n) @(posedge clock);
    endtask

    // monitor: read data stand only the cycle after the strobe
    always @(posedge clock) begin
        if (rd_pend) begin
            chk_byte(exp_q.pop_front(), rd_data);
        end
        rd_pend <= rd_stb;
    end

    // hang guard, far above the run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            summarize();
        end
    end

    // main sequence
    initial begin
        seed = 94358;
        {addr, wr_data, wr_stb, rd_stb, rd_pend} = '0;
        {sys_clock_src_ok, pin_a2_direction, ack_en, ext_run, rst_n} = 5'b10000;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        // reset values, reserved bits, unmapped places
        rd(3'h1, 8'h00);
        rd(3'h2, 8'h00);
        rd(3'h4, 8'h00);
        wr(3'h4, 8'h9f);
        wr(3'h6, 8'hff);
        rd(3'h4, 8'h00);
        rd(3'h3, 8'h00);
        rd(3'h6, 8'h00);
        rd(3'h7, 8'h00);
        // random loads: read back, then one count on
        repeat (4) begin
            val = t8_byte_t'($random(seed));
            wr(3'h0, val);
            rd(3'h0, val);
            rd(3'h0, val + 8'h01);
        end
        // wrap from the top sets overflow
        wr(3'h5, 8'h03);
        wr(3'h0, 8'hfe);
        rd(3'h0, 8'hfe);
        rd(3'h0, 8'hff);
        rd(3'h0, 8'h00);
        idle(1);
        @(negedge clock);
        chk_bit("overflow_flag", 1'b1, overflow_flag);
        @(posedge clock);
        // taking the interrupt clears it
        ack_en <= 1'b1;
        idle(4);
        ack_en <= 1'b0;
        @(negedge clock);
        chk_bit("overflow_flag", 1'b0, overflow_flag);
        @(posedge clock);
        // clear-on-match, top at five
        pin_a2_direction <= 1'b1;
        wr(3'h1, 8'h05);
        wr(3'h2, 8'h42);
        wr(3'h5, 8'h03);
        wr(3'h0, 8'h00);
        for (int i = 0; i < 14; i++) begin
            rd(3'h0, t8_byte_t'(i % 6));
        end
        idle(1);
        @(negedge clock);
        chk_bit("compare_flag", 1'b1, compare_flag);
        chk_bit("compare_output_a_oe", 1'b1, compare_output_a_oe);
        @(posedge clock);
        // set, clear and no-action output modes each act at the next match
        for (int k = 0; k < 5; k++) begin
            wr(3'h2, {com_tab[k], 6'h02});
            idle(8);
            @(negedge clock);
            chk_bit("compare_output_a_pin", pin_tab[k], compare_output_a_pin);
            @(posedge clock);
        end
        // force toggles at once, no flag
        wr(3'h2, 8'h40);
        wr(3'h1, 8'h80);
        wr(3'h0, 8'h00);
        wr(3'h5, 8'h03);
        wr(3'h3, 8'h80);
        idle(2);
        @(negedge clock);
        chk_bit("compare_output_a_pin", 1'b0, compare_output_a_pin);
        chk_bit("compare_flag", 1'b0, compare_flag);
        @(posedge clock);
        // external clock: enable first, then async
        wr(3'h2, 8'h00);
        wr(3'h4, 8'h40);
        wr(3'h4, 8'h60);
        idle(2);
        @(negedge clock);
        chk_bit("xtal_osc_en", 1'b0, xtal_osc_en);
        chk_bit("ext_clk_buf_en", 1'b1, ext_clk_buf_en);
        @(posedge clock);
        // writes park while the source stands still
        wr(3'h0, 8'h33);
        wr(3'h1, 8'h10);
        wr(3'h2, 8'h00);
        wr(3'h3, 8'h00);
        idle(1);
        rd(3'h4, 8'h7b);
        ext_run <= 1'b1;
        idle(60);
        rd(3'h4, 8'h60);
        // unsuitable system clock forces sync
        sys_clock_src_ok <= 1'b0;
        idle(3);
        rd(3'h4, 8'h40);
        ext_run <= 1'b0;
        sys_clock_src_ok <= 1'b1;
        // slow oscillator path keeps the crystal on
        wr(3'h4, 8'h20);
        idle(2);
        @(negedge clock);
        chk_bit("ext_clk_buf_en", 1'b0, ext_clk_buf_en);
        chk_bit("xtal_osc_en", 1'b1, xtal_osc_en);
        @(posedge clock);
        rd(3'h4, 8'h20);
        wr(3'h4, 8'h00);
        // source changed: rewrite counter, compare, control
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h00);
        wr(3'h2, 8'h00);
        idle(4);
        summarize();
    end
endmodule

`default_nettype wire
